/* File: pkg/dgw_pkg.sv */
// Shared constants and types for the data gateway timestamp framer
// What this block does
// - Timestamp service uses identifier 0x00; 0xFF means no interface selected.
// - SPI source tagged 0x20, UART source 0x21, I2C source 0x22.
// - Pin monitor tagged 0x30, power data 0x40, program-counter polling 0x50.
// - Every stream packet starts with the source interface identifier byte.
// - Free-running 16-bit timer value is captured into each timestamped packet.
// - A timer wrap not flagged in a packet header inserts a dedicated overflow packet into the stream.
// - Wrap pending when a timestamped packet sends its header is flagged there, no overflow packet.
// - Header overflow flag is sampled after the timer value was captured.
// - Every packet from a timestamp-enabled source carries a timestamp; a byte overwritten in its slot before framing is lost.
// - Timer tick frequency is readable; nominal tick about half a microsecond.
// - SPI chip select is active low; bits clocked while it is high are dropped.
// - SPI client forwards raw received characters unmodified into the stream.
// - Serial bridges support exactly twelve baud rates from 7200 to 921600.
// - Target UART is bridged both ways to the host as a serial port.
// - Host can read which gateway interfaces this build implements.
// - SPI character length selectable as 5, 6, 7 or 8 bits.
package dgw_pkg;

  localparam logic [7:0] ID_TS   = 8'h00;
  localparam logic [7:0] ID_NONE = 8'hff;
  localparam logic [7:0] ID_SPI  = 8'h20;
  localparam logic [7:0] ID_UART = 8'h21;
  localparam logic [7:0] ID_I2C  = 8'h22;
  localparam logic [7:0] ID_GPIO = 8'h30;
  localparam logic [7:0] ID_PWR  = 8'h40;
  localparam logic [7:0] ID_PC   = 8'h50;

  localparam int NSRC     = 5;
  localparam int SRC_SPI  = 0;
  localparam int SRC_UART = 1;
  localparam int SRC_GPIO = 2;
  localparam int SRC_PWR  = 3;
  localparam int SRC_PC   = 4;
  localparam logic [7:0] SRC_ID [NSRC] = '{ID_SPI, ID_UART, ID_GPIO, ID_PWR, ID_PC};

  // Implemented-interface mask bits
  localparam int MAP_TS   = 0;
  localparam int MAP_SPI  = 1;
  localparam int MAP_UART = 2;
  localparam int MAP_I2C  = 3;
  localparam int MAP_GPIO = 4;
  localparam int MAP_PWR  = 5;
  localparam int MAP_PC   = 6;
  localparam logic [7:0] IFACE_MAP_RST = 8'h77;

  localparam int HDR_OVF_BIT = 0;

  localparam int CLK_HZ   = 20_000_000;
  localparam int TICK_NS  = 500;
  localparam int TICK_CYC = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [31:0] TICK_HZ = 32'(CLK_HZ / TICK_CYC);
  localparam logic [15:0] TS_MAX = 16'hffff;

  localparam int NBAUD = 12;
  localparam logic [3:0] BAUD_SEL_RST = 4'h8;
  localparam logic [15:0] BAUD_DIV [NBAUD] = '{
    16'(CLK_HZ / 7200),   16'(CLK_HZ / 9600),   16'(CLK_HZ / 14400),  16'(CLK_HZ / 19200),
    16'(CLK_HZ / 28800),  16'(CLK_HZ / 38400),  16'(CLK_HZ / 57600),  16'(CLK_HZ / 76800),
    16'(CLK_HZ / 115200), 16'(CLK_HZ / 230400), 16'(CLK_HZ / 460800), 16'(CLK_HZ / 921600)};

  localparam logic [2:0] SPI_LEN_BASE = 3'h4;
  localparam logic [3:0] UART_FRAME_BITS = 4'ha;

  typedef enum logic [2:0] {
    FS_IDLE = 3'b000,
    FS_ID   = 3'b001,
    FS_HDR  = 3'b010,
    FS_TSH  = 3'b011,
    FS_TSL  = 3'b100,
    FS_DATA = 3'b101
  } dgw_fstate_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } dgw_rxstate_e;

endpackage

/* File: pkg/dgw_stream_if.sv */
// Byte stream carrier with valid and ready between framer and buffer
`timescale 1ns/10ps
interface dgw_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: logic/dgw_skid.sv */
// Two-entry buffer with registered outputs on both sides
`timescale 1ns/10ps
module dgw_skid #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic   i_clk,
  input wire logic   i_rst,
  // Stream in and out
  dgw_stream_if.snk  s_in,
  dgw_stream_if.src  s_out
);

  if (W < 1) begin : g_chk
    $error("dgw_skid: W must be at least 1");
  end

  logic         out_v;
  logic [W-1:0] out_d;
  logic         skid_v;
  logic [W-1:0] skid_d;
  logic         in_rdy;
  logic         take;
  logic         next_skid_v;

  assign s_out.valid = out_v;
  assign s_out.data  = out_d;
  assign s_in.ready  = in_rdy;
  assign take        = s_in.valid & in_rdy;

  always_comb begin
    next_skid_v = skid_v;
    if (!out_v || s_out.ready) begin
      next_skid_v = 1'b0;
    end else if (take) begin
      next_skid_v = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_v  <= 1'b0;
      skid_v <= 1'b0;
      in_rdy <= 1'b1;
    end else begin
      skid_v <= next_skid_v;
      // Ready is registered, so a word already in flight lands in the skid slot
      in_rdy <= !next_skid_v;
      if (!out_v || s_out.ready) begin
        out_v <= skid_v | take;
        if (skid_v) begin
          out_d <= skid_d;
        end else if (take) begin
          out_d <= s_in.data;
        end
      end else if (take) begin
        skid_d <= s_in.data;
      end
    end
  end

endmodule

/* File: logic/dgw_framer.sv */
// Data gateway: client receivers, timestamp framer and serial bridge
`timescale 1ns/10ps
module dgw_framer #(
  parameter int                 TICK_CYC  = dgw_pkg::TICK_CYC,
  parameter logic [7:0]         IFACE_MAP = dgw_pkg::IFACE_MAP_RST
) (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  // SPI client pins
  input  wire logic                     i_spi_sclk,
  input  wire logic                     i_spi_cs_n,
  input  wire logic                     i_spi_mosi,
  // SPI settings
  input  wire logic [1:0]               i_spi_len,
  input  wire logic                     i_spi_cpol,
  input  wire logic                     i_spi_cpha,
  // UART pins and settings
  input  wire logic                     i_uart_rx,
  output logic                          o_uart_tx,
  input  wire logic [3:0]               i_baud_sel,
  // Pin monitor
  input  wire logic [3:0]               i_gpio,
  input  wire logic [3:0]               i_gpio_trig,
  // Power and program-counter samples
  input  wire logic                     i_pwr_valid,
  input  wire logic [7:0]               i_pwr_data,
  input  wire logic                     i_pc_valid,
  input  wire logic [7:0]               i_pc_data,
  // Timestamp enables, one per source
  input  wire logic [dgw_pkg::NSRC-1:0] i_ts_en,
  // Packet stream to host
  output logic [7:0]                    o_usb_data,
  output logic                          o_usb_valid,
  input  wire logic                     i_usb_ready,
  // Host bytes to target UART
  input  wire logic [7:0]               i_host_data,
  input  wire logic                     i_host_valid,
  output logic                          o_host_ready,
  // Configuration readback
  output logic [31:0]                   o_tick_hz,
  output logic [7:0]                    o_iface_map
);

  localparam int NS = dgw_pkg::NSRC;

  if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_chk
    $error("dgw_framer: TICK_CYC out of range");
  end

  // ---------------- Pin synchronisers
  logic [7:0] pin_meta;
  logic [7:0] pin_s;

  always_ff @(posedge i_clk) begin
    pin_meta <= {i_gpio, i_uart_rx, i_spi_mosi, i_spi_cs_n, i_spi_sclk};
    pin_s    <= pin_meta;
  end

  logic       sclk_s;
  logic       cs_n_s;
  logic       mosi_s;
  logic       rx_s;
  logic [3:0] gpio_s;
  assign sclk_s = pin_s[0];
  assign cs_n_s = pin_s[1];
  assign mosi_s = pin_s[2];
  assign rx_s   = pin_s[3];
  assign gpio_s = pin_s[7:4];

  // ---------------- Configuration readback
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tick_hz   <= 32'h0;
      o_iface_map <= 8'h0;
    end else begin
      o_tick_hz   <= 32'(dgw_pkg::CLK_HZ / TICK_CYC);
      o_iface_map <= IFACE_MAP;
    end
  end

  // ---------------- Timestamp timer
  logic [15:0] tick_cnt;
  logic        tick;
  logic [15:0] ts;
  logic        wrap;

  assign tick = (tick_cnt == 16'(TICK_CYC - 1));
  assign wrap = tick && (ts == dgw_pkg::TS_MAX);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tick_cnt <= 16'h0;
      ts       <= 16'h0;
    end else begin
      tick_cnt <= tick ? 16'h0 : tick_cnt + 16'h1;
      if (tick) begin
        ts <= ts + 16'h1;
      end
    end
  end

  // ---------------- SPI client receiver
  logic       sclk_d;
  logic [2:0] spi_bits;
  logic [7:0] spi_sh;
  logic       spi_samp;
  logic [2:0] spi_last;
  logic [7:0] spi_next;
  logic       spi_done;
  logic [7:0] spi_byte;

  assign spi_last = dgw_pkg::SPI_LEN_BASE + {1'b0, i_spi_len};
  assign spi_samp = (i_spi_cpol ^ i_spi_cpha) ? (sclk_d & !sclk_s) : (!sclk_d & sclk_s);
  assign spi_next = {spi_sh[6:0], mosi_s};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Track the pin so an idle-high clock gives no false edge after reset
      sclk_d   <= sclk_s;
      spi_bits <= 3'h0;
      spi_done <= 1'b0;
    end else begin
      sclk_d   <= sclk_s;
      spi_done <= 1'b0;
      if (cs_n_s) begin
        spi_bits <= 3'h0;
      end else if (spi_samp) begin
        spi_sh <= spi_next;
        if (spi_bits == spi_last) begin
          spi_bits <= 3'h0;
          spi_done <= 1'b1;
          spi_byte <= spi_next & (8'hff >> (3'h7 - spi_last));
        end else begin
          spi_bits <= spi_bits + 3'h1;
        end
      end
    end
  end

  // ---------------- UART bit timing
  logic [15:0] baud_div;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      baud_div <= dgw_pkg::BAUD_DIV[dgw_pkg::BAUD_SEL_RST];
    end else if (i_baud_sel < 4'(dgw_pkg::NBAUD)) begin
      baud_div <= dgw_pkg::BAUD_DIV[i_baud_sel];
    end
  end

  // ---------------- UART receiver, 8N1
  dgw_pkg::dgw_rxstate_e rx_st;
  logic [15:0]           rx_cnt;
  logic [2:0]            rx_bits;
  logic [7:0]            rx_sh;
  logic                  rx_done;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_st   <= dgw_pkg::RX_IDLE;
      rx_cnt  <= 16'h0;
      rx_bits <= 3'h0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (rx_cnt != 16'h0) begin
        rx_cnt <= rx_cnt - 16'h1;
      end else begin
        case (rx_st)
          dgw_pkg::RX_IDLE: begin
            if (!rx_s) begin
              rx_cnt <= {1'b0, baud_div[15:1]};
              rx_st  <= dgw_pkg::RX_START;
            end
          end
          dgw_pkg::RX_START: begin
            // Glitch shorter than half a bit is rejected
            rx_st   <= rx_s ? dgw_pkg::RX_IDLE : dgw_pkg::RX_DATA;
            rx_cnt  <= baud_div - 16'h1;
            rx_bits <= 3'h0;
          end
          dgw_pkg::RX_DATA: begin
            rx_sh   <= {rx_s, rx_sh[7:1]};
            rx_cnt  <= baud_div - 16'h1;
            rx_bits <= rx_bits + 3'h1;
            if (rx_bits == 3'h7) begin
              rx_st <= dgw_pkg::RX_STOP;
            end
          end
          dgw_pkg::RX_STOP: begin
            rx_done <= rx_s;
            rx_st   <= dgw_pkg::RX_IDLE;
          end
          default: begin
            rx_st <= dgw_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------- UART transmitter, 8N1
  logic [15:0] tx_cnt;
  logic [3:0]  tx_left;
  logic [8:0]  tx_sh;
  logic        host_take;

  assign host_take = i_host_valid & o_host_ready;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_uart_tx    <= 1'b1;
      o_host_ready <= 1'b1;
      tx_left      <= 4'h0;
      tx_cnt       <= 16'h0;
      tx_sh        <= 9'h1ff;
    end else if (host_take) begin
      o_uart_tx    <= 1'b0;
      o_host_ready <= 1'b0;
      tx_sh        <= {1'b1, i_host_data};
      tx_left      <= dgw_pkg::UART_FRAME_BITS;
      tx_cnt       <= baud_div - 16'h1;
    end else if (tx_left != 4'h0) begin
      if (tx_cnt != 16'h0) begin
        tx_cnt <= tx_cnt - 16'h1;
      end else if (tx_left == 4'h1) begin
        tx_left      <= 4'h0;
        o_host_ready <= 1'b1;
      end else begin
        o_uart_tx <= tx_sh[0];
        tx_sh     <= {1'b1, tx_sh[8:1]};
        tx_left   <= tx_left - 4'h1;
        tx_cnt    <= baud_div - 16'h1;
      end
    end
  end

  // ---------------- Pin monitor
  logic [3:0] gpio_d;
  logic       gpio_chg;

  assign gpio_chg = |((gpio_s ^ gpio_d) & i_gpio_trig);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Pins idling high must not look like a change once reset ends
      gpio_d <= gpio_s;
    end else begin
      gpio_d <= gpio_s;
    end
  end

  // ---------------- Source holding slots
  logic [NS-1:0] src_new;
  logic [7:0]    src_byte [NS];
  logic [NS-1:0] pend;
  logic [7:0]    hold [NS];

  assign src_new[dgw_pkg::SRC_SPI]   = spi_done;
  assign src_byte[dgw_pkg::SRC_SPI]  = spi_byte;
  assign src_new[dgw_pkg::SRC_UART]  = rx_done;
  assign src_byte[dgw_pkg::SRC_UART] = rx_sh;
  assign src_new[dgw_pkg::SRC_GPIO]  = gpio_chg;
  assign src_byte[dgw_pkg::SRC_GPIO] = {4'h0, gpio_s};
  assign src_new[dgw_pkg::SRC_PWR]   = i_pwr_valid;
  assign src_byte[dgw_pkg::SRC_PWR]  = i_pwr_data;
  assign src_new[dgw_pkg::SRC_PC]    = i_pc_valid;
  assign src_byte[dgw_pkg::SRC_PC]   = i_pc_data;

  // Fixed priority, lowest index first
  logic       found;
  logic [2:0] pick;

  always_comb begin
    found = 1'b0;
    pick  = 3'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        found = 1'b1;
        pick  = 3'(i);
      end
    end
  end

  dgw_pkg::dgw_fstate_e st;
  logic                 grant;

  assign grant = (st == dgw_pkg::FS_IDLE) && found;

  // A slot holds one byte; a newer byte overwrites one not yet framed
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend <= '0;
    end else begin
      for (int i = 0; i < NS; i++) begin
        if (src_new[i]) begin
          pend[i] <= 1'b1;
          hold[i] <= src_byte[i];
        end else if (grant && pick == 3'(i)) begin
          pend[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------- Packet framer
  dgw_stream_if #(.W(8)) fr_if ();
  dgw_stream_if #(.W(8)) out_if ();

  logic [7:0]  cur_id;
  logic [15:0] ts_cap;
  logic        ts_on;
  logic        is_ovf;
  logic [7:0]  dat;
  logic        ovf_pend;
  logic        acc;
  logic        hdr_acc;

  assign acc     = fr_if.valid & fr_if.ready;
  assign hdr_acc = acc && (st == dgw_pkg::FS_HDR);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ovf_pend <= 1'b0;
    end else begin
      ovf_pend <= wrap | (ovf_pend & !hdr_acc);
    end
  end

  always_comb begin
    fr_if.valid = (st != dgw_pkg::FS_IDLE);
    case (st)
      dgw_pkg::FS_ID:   fr_if.data = cur_id;
      // flag sampled after the captured count
      dgw_pkg::FS_HDR:  fr_if.data = 8'(ovf_pend) << dgw_pkg::HDR_OVF_BIT;
      dgw_pkg::FS_TSH:  fr_if.data = ts_cap[15:8];
      dgw_pkg::FS_TSL:  fr_if.data = ts_cap[7:0];
      dgw_pkg::FS_DATA: fr_if.data = dat;
      default:          fr_if.data = 8'h0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st     <= dgw_pkg::FS_IDLE;
      cur_id <= dgw_pkg::ID_NONE;
      ts_on  <= 1'b0;
      is_ovf <= 1'b0;
      ts_cap <= 16'h0;
      dat    <= 8'h0;
    end else begin
      case (st)
        dgw_pkg::FS_IDLE: begin
          // data first, a timestamped data header carries the wrap
          if (found) begin
            cur_id <= dgw_pkg::SRC_ID[pick];
            ts_on  <= i_ts_en[pick];
            ts_cap <= ts;
            dat    <= hold[pick];
            is_ovf <= 1'b0;
            st     <= dgw_pkg::FS_ID;
          end else if (ovf_pend) begin
            cur_id <= dgw_pkg::ID_TS;
            is_ovf <= 1'b1;
            ts_on  <= 1'b0;
            st     <= dgw_pkg::FS_ID;
          end else begin
            cur_id <= dgw_pkg::ID_NONE;
          end
        end
        dgw_pkg::FS_ID: begin
          if (acc) begin
            st <= (is_ovf || ts_on) ? dgw_pkg::FS_HDR : dgw_pkg::FS_DATA;
          end
        end
        dgw_pkg::FS_HDR: begin
          if (acc) begin
            st <= is_ovf ? dgw_pkg::FS_IDLE : dgw_pkg::FS_TSH;
          end
        end
        dgw_pkg::FS_TSH: begin
          if (acc) begin
            st <= dgw_pkg::FS_TSL;
          end
        end
        dgw_pkg::FS_TSL: begin
          if (acc) begin
            st <= dgw_pkg::FS_DATA;
          end
        end
        dgw_pkg::FS_DATA: begin
          if (acc) begin
            st     <= dgw_pkg::FS_IDLE;
            cur_id <= dgw_pkg::ID_NONE;
          end
        end
        default: begin
          st <= dgw_pkg::FS_IDLE;
        end
      endcase
    end
  end

  // ---------------- Output buffer; host stall backs up into the framer
  dgw_skid #(.W(8)) u_buf (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .s_in  (fr_if.snk),
    .s_out (out_if.src)
  );

  assign out_if.ready = i_usb_ready;
  assign o_usb_data   = out_if.data;
  assign o_usb_valid  = out_if.valid;

endmodule

/* File: testbench/dgw_framer_monitor.sv */
// Port-level assertion checker for the gateway framer
`timescale 1ns/10ps
module dgw_framer_monitor #(
  parameter int         TICK_CYC  = dgw_pkg::TICK_CYC,
  parameter logic [7:0] IFACE_MAP = dgw_pkg::IFACE_MAP_RST
) (
  // Watched ports
  input wire logic                     i_clk,
  input wire logic                     i_rst,
  input wire logic [dgw_pkg::NSRC-1:0] i_ts_en,
  input wire logic [7:0]               o_usb_data,
  input wire logic                     o_usb_valid,
  input wire logic                     i_usb_ready,
  input wire logic                     i_host_valid,
  input wire logic                     o_host_ready,
  input wire logic                     o_uart_tx,
  input wire logic [31:0]              o_tick_hz,
  input wire logic [7:0]               o_iface_map
);
  localparam logic [31:0] HZ = 32'(dgw_pkg::CLK_HZ / TICK_CYC);
  logic       acc;
  logic       stamped;
  logic [2:0] pos;
  logic [7:0] pid;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  assign acc = o_usb_valid && i_usb_ready;
  always_comb begin
    case (pid)
      8'h20: stamped = i_ts_en[0];
      8'h21: stamped = i_ts_en[1];
      8'h30: stamped = i_ts_en[2];
      8'h40: stamped = i_ts_en[3];
      8'h50: stamped = i_ts_en[4];
      default: stamped = 1'b0;
    endcase
  end
  // Byte position inside the current packet
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pos <= 3'h0;
    end else if (acc && pos == 3'h0) begin
      pos <= 3'h1;
      pid <= o_usb_data;
    end else if (acc) begin
      pos <= (pos == (stamped ? 3'h4 : 3'h1)) ? 3'h0 : pos + 3'h1;
    end
  end
  sequence s_take;
    i_host_valid && o_host_ready;
  endsequence
  sequence s_start_bit;
    (!o_uart_tx && !o_host_ready) [*8];
  endsequence
  AST_STREAM_HOLD: assert property (o_usb_valid && !i_usb_ready |=> o_usb_valid && $stable(o_usb_data))
    else $error("stream byte changed before accept");
  AST_TICK_HZ: assert property (!$past(i_rst) |-> o_tick_hz == HZ)
    else $error("tick rate readback wrong");
  AST_IFACE_MAP: assert property (!$past(i_rst) |-> o_iface_map == IFACE_MAP)
    else $error("interface map readback wrong");
  AST_RESET_IDLE: assert property (disable iff (1'b0) i_rst |=> !o_usb_valid && o_uart_tx && o_tick_hz == 32'h0)
    else $error("outputs not idle in reset");
  AST_TX_START: assert property (s_take |=> s_start_bit)
    else $error("start bit missing after host byte");
  AST_TX_IDLE: assert property (o_host_ready |-> o_uart_tx)
    else $error("serial line low while idle");
  AST_PKT_ID: assert property (acc && pos == 3'h0 |-> o_usb_data inside {8'h00, 8'h20, 8'h21, 8'h30, 8'h40, 8'h50})
    else $error("packet starts with unknown identifier");
  AST_OVF_HDR: assert property (acc && pos == 3'h1 && pid == 8'h00 |-> o_usb_data == 8'h01)
    else $error("overflow packet header wrong");
  AST_HDR_ZERO: assert property (acc && pos == 3'h1 && stamped |-> o_usb_data[7:1] == 7'h0)
    else $error("header spare bits set");
endmodule
bind dgw_framer dgw_framer_monitor #(.TICK_CYC(TICK_CYC), .IFACE_MAP(IFACE_MAP)) u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_ts_en(i_ts_en), .o_usb_data(o_usb_data), .o_usb_valid(o_usb_valid),
  .i_usb_ready(i_usb_ready), .i_host_valid(i_host_valid), .o_host_ready(o_host_ready),
  .o_uart_tx(o_uart_tx), .o_tick_hz(o_tick_hz), .o_iface_map(o_iface_map));

/* File: testbench/dgw_far_model.sv */
// Far side model: target pins and a host sink that can stall
`timescale 1ns/10ps
module dgw_far_model (
  // Clock
  input  wire logic       i_clk,
  // Host sink
  input  wire logic [7:0] i_usb_data,
  input  wire logic       i_usb_valid,
  output logic            o_usb_ready,
  input  wire logic       i_stall,
  // Target pins
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic            o_mosi,
  output logic            o_uart
);
  logic [7:0] rxq[$];
  logic [1:0] ph = 2'h0;
  initial begin
    o_usb_ready = 1'b1;
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_uart = 1'b1;
  end
  // Stalls two cycles in four so the buffer fills and refuses
  always @(negedge i_clk) begin
    ph <= ph + 2'h1;
    o_usb_ready <= !i_stall || ph[1];
  end
  always @(posedge i_clk) begin
    if (i_usb_valid && o_usb_ready) rxq.push_back(i_usb_data);
  end
  task automatic spi_xfer(input int n, input logic [7:0] v, input logic cpol, input logic cpha, input logic cs);
    @(negedge i_clk);
    o_sclk = cpol;
    o_cs_n = cs;
    for (int i = n - 1; i >= 0; i--) begin
      if (!cpha) o_mosi = v[i];
      repeat (4) @(negedge i_clk);
      o_sclk = !cpol;
      if (cpha) o_mosi = v[i];
      repeat (4) @(negedge i_clk);
      o_sclk = cpol;
    end
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    // Released data line shows the inverse, never a stale level
    o_mosi = !o_mosi;
  endtask
  task automatic uart_send(input int div, input logic [9:0] fr);
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clk);
      o_uart = fr[i];
      repeat (div - 1) @(negedge i_clk);
    end
    o_uart = 1'b1;
  endtask
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the gateway framer
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", nm, e, a); end end
module tb;
  localparam int DIV = 21;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sclk, cs_n, mosi, urx, utx, usb_v, usb_r, h_v, h_r, stall = 1'b0;
  logic cpol = 1'b0, cpha = 1'b0, pwr_v = 1'b0, pc_v = 1'b0;
  logic [1:0] len = 2'h0;
  logic [3:0] baud = 4'hb, gpio = 4'h0, trig = 4'h0;
  logic [4:0] ts_en = 5'h0;
  logic [7:0] pwr_d = 8'h0, pc_d = 8'h0, h_d = 8'h0, usb_d, imap, b;
  logic [31:0] thz;
  int bad_count = 0;
  int checks_done = 0;
  always #25 i_clk = ~i_clk;
  // One tick per clock, so the 16-bit timer wraps early enough to be seen in the run
  dgw_framer #(.TICK_CYC(1)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
    .i_spi_len(len), .i_spi_cpol(cpol), .i_spi_cpha(cpha), .i_uart_rx(urx), .o_uart_tx(utx),
    .i_baud_sel(baud), .i_gpio(gpio), .i_gpio_trig(trig), .i_pwr_valid(pwr_v), .i_pwr_data(pwr_d),
    .i_pc_valid(pc_v), .i_pc_data(pc_d), .i_ts_en(ts_en), .o_usb_data(usb_d), .o_usb_valid(usb_v),
    .i_usb_ready(usb_r), .i_host_data(h_d), .i_host_valid(h_v), .o_host_ready(h_r),
    .o_tick_hz(thz), .o_iface_map(imap));
  dgw_far_model u_far (
    .i_clk(i_clk), .i_usb_data(usb_d), .i_usb_valid(usb_v), .o_usb_ready(usb_r), .i_stall(stall),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .o_uart(urx));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic getb(input int lim, output logic [7:0] v);
    int n;
    n = 0;
    while (u_far.rxq.size() == 0 && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    if (u_far.rxq.size() == 0) begin
      bad_count++;
      $display("unexpected stream byte missing");
      print_verdict();
    end else v = u_far.rxq.pop_front();
  endtask
  task automatic expb(input logic [7:0] e);
    getb(4000, b);
    `CHK("stream byte", e, b)
  endtask
  task automatic quiet(input int n);
    repeat (n) @(negedge i_clk);
    `CHK("stray bytes", 0, u_far.rxq.size())
  endtask
  task automatic t_pwr();
    logic [15:0] t1, t2;
    ts_en = 5'h1f;
    stall = 1'b1;
    pwr_d = 8'ha5;
    pwr_v = 1'b1;
    @(negedge i_clk);
    pwr_v = 1'b0;
    repeat (59) @(negedge i_clk);
    pwr_d = 8'h5b;
    pwr_v = 1'b1;
    @(negedge i_clk);
    pwr_v = 1'b0;
    expb(8'h40);
    expb(8'h00);
    getb(4000, t1[15:8]);
    getb(4000, t1[7:0]);
    expb(8'ha5);
    expb(8'h40);
    expb(8'h00);
    getb(4000, t2[15:8]);
    getb(4000, t2[7:0]);
    expb(8'h5b);
    `CHK("stamp step", 1'b1, (t2 - t1) inside {[16'd59:16'd61]})
    stall = 1'b0;
    ts_en = 5'h0;
    $display("test pwr done");
  endtask
  task automatic t_pri();
    pwr_d = 8'h11;
    pc_d = 8'h22;
    pwr_v = 1'b1;
    pc_v = 1'b1;
    @(negedge i_clk);
    pwr_v = 1'b0;
    pc_v = 1'b0;
    expb(8'h40);
    expb(8'h11);
    expb(8'h50);
    expb(8'h22);
    $display("test priority done");
  endtask
  task automatic t_spi();
    for (int k = 0; k < 4; k++) begin
      len = 2'(k);
      cpol = k[1];
      cpha = k[0];
      u_far.spi_xfer(5 + k, 8'hb5, cpol, cpha, 1'b0);
      expb(8'h20);
      expb(8'hb5 & (8'hff >> (3 - k)));
    end
    u_far.spi_xfer(8, 8'h3c, cpol, cpha, 1'b1);
    quiet(100);
    $display("test spi done");
  endtask
  task automatic t_gpio();
    trig = 4'h8;
    gpio = 4'h1;
    quiet(30);
    gpio = 4'h9;
    expb(8'h30);
    expb(8'h09);
    $display("test gpio done");
  endtask
  task automatic t_urx();
    u_far.uart_send(DIV, {1'b1, 8'h5a, 1'b0});
    expb(8'h21);
    expb(8'h5a);
    u_far.uart_send(DIV, {1'b0, 8'h66, 1'b0});
    quiet(60);
    $display("test uart rx done");
  endtask
  task automatic t_htx();
    logic [9:0] fr;
    int n;
    baud = 4'hf;
    h_d = 8'hc3;
    h_v = 1'b1;
    @(negedge i_clk);
    h_v = 1'b0;
    n = 0;
    while (utx !== 1'b0 && n < 10) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 10) begin
      bad_count++;
      $display("unexpected start bit missing");
      print_verdict();
    end
    repeat (DIV / 2) @(negedge i_clk);
    for (int i = 0; i < 10; i++) begin
      fr[i] = utx;
      repeat (DIV) @(negedge i_clk);
    end
    `CHK("tx frame", {1'b1, 8'hc3, 1'b0}, fr)
    repeat (DIV) @(negedge i_clk);
    `CHK("host ready", 1'b1, h_r)
    $display("test uart tx done");
  endtask
  task automatic t_wrap();
    getb(70000, b);
    `CHK("overflow id", 8'h00, b)
    expb(8'h01);
    $display("test wrap done");
  endtask
  initial begin
    h_v = 1'b0;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    `CHK("tick rate", 32'd20000000, thz)
    `CHK("iface map", 8'h77, imap)
    t_pwr();
    t_pri();
    t_spi();
    t_gpio();
    t_urx();
    t_htx();
    t_wrap();
    print_verdict();
  end
endmodule
